// ---- pkg/ptp_trig_map.vh ----
// register offsets, field positions, reset values and timing constants of the trigger waveform block
`ifndef PTP_TRIG_MAP_VH
`define PTP_TRIG_MAP_VH

// register byte offsets
`define REG_CTRL_ONE 8'h00
`define REG_CYCLE_WIDTH 8'h04
`define REG_COUNT_PATTERN 8'h08
`define REG_PULSE_WIDTH 8'h0c
`define REG_UNIT_CTRL 8'h10
`define REG_UNIT_STATUS 8'h14

// control one fields
`define CASC_EN_BIT 31
`define CASC_TAIL_BIT 30
`define WAVE_SEL_HI 22
`define WAVE_SEL_LO 20
`define REPEAT_HI 15
`define REPEAT_LO 0
`define CTRL_ONE_RESET 32'h0000_0000

// count/pattern fields
`define CYC_COUNT_HI 31
`define CYC_COUNT_LO 16
`define PATTERN_HI 15
`define PATTERN_LO 0

// unit control fields
`define TRIGGER_UNIT_ENABLE_BIT 0
`define TAIL_PRESENT_BIT 1

// wave select codes
`define WAVE_FALL 3'h0
`define WAVE_RISE 3'h1
`define WAVE_LOW_PULSE 3'h2
`define WAVE_HIGH_PULSE 3'h3
`define WAVE_LOW_PERIODIC 3'h4
`define WAVE_HIGH_PERIODIC 3'h5
`define WAVE_PATTERN 3'h6

// timing
`define CLK_PERIOD_NS 10
`define PULSE_UNIT_NS 8
`define CYCLE_UNIT_NS 1
`define TOGGLE_MAX_KHZ 12500
`define MIN_SEG_NS (1000000 / (2 * `TOGGLE_MAX_KHZ))

`endif

// ---- design/ns_span_timer.v ----
// elapsed-time counter in ns with two threshold compares
`timescale 1ns/1ps
`include "ptp_trig_map.vh"
module ns_span_timer #(
   parameter TW = 34
) (
   input wire pclk,
   input wire presetn,
   input wire restart,
   input wire [TW-1:0] target_a,
   input wire [TW-1:0] target_b,
   output wire hit_a,
   output wire hit_b
);
   localparam [TW-1:0] STEP = `CLK_PERIOD_NS;
   reg [TW-1:0] elapsed;
   wire [TW-1:0] after_step;

   assign after_step = elapsed + STEP;
   // compare against time at the end of this cycle: least times round up
   assign hit_a = (after_step >= target_a);
   assign hit_b = (after_step >= target_b);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed <= {TW{1'b0}};
      end else if (restart) begin
         elapsed <= {TW{1'b0}};
      end else if (after_step > elapsed) begin
         // saturate instead of wrapping on very long segments
         elapsed <= after_step;
      end
   end
endmodule

// ---- design/ptp_trigger_waveform_select.v ----
// trigger output waveform generator with apb register file
// How it works
// (R1) a waveform starts only when trigger_unit_enable is set and the target time has been reached.
// (R2) the wave select field sits at bits 22:20, resets to 000 and code 111 is reserved.
// (R3) code 000 drives a falling edge from high idle and then stays low.
// (R4) code 001 drives a rising edge and then stays high.
// (R5) code 010 drives one low pulse of the programmed pulse width from high idle, then stays high.
// (R6) code 011 drives one high pulse of the programmed pulse width from low idle, then stays low.
// (R7) code 100 drives periodic low pulses by pulse width, cycle width and cycle count, zero count endless.
// (R8) code 101 drives periodic high pulses by pulse width, cycle width and cycle count, zero count endless.
// (R9) code 110 shifts the 16-bit pattern msb first in a loop, one bit per cycle width, count bits, zero endless.
// (R10) toggle rate is limited to 12.5 MHz, so no level is held shorter than half that period; the code clamps pulse and cycle width, not the periodic rest.
// (R11) repeat count sits at bits 15:0, resets to zero, and the tail unit sends the pattern count plus one times.
// (R12) in a cascade chain with no tail unit the repeat count is ignored and the pattern runs forever.
// (R13) the pulse width setting counts in 8 ns units.
// (R14) the cycle width setting counts in 1 ns units, also as the pattern bit time.
// (R15) only a unit flagged as chain tail applies the repeat count.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "ptp_trig_map.vh"
module ptp_trigger_waveform_select #(
   parameter PATTERN_BITS = 16,
   parameter TW = 34
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire time_reached,
   output reg wave_out
);
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_ACT = 4'b0010;
   localparam [3:0] S_REST = 4'b0100;
   localparam [3:0] S_HOLD = 4'b1000;
   localparam [TW-1:0] MIN_SEG = `MIN_SEG_NS;
   localparam [TW-1:0] PULSE_UNIT = `PULSE_UNIT_NS;
   localparam [TW-1:0] CYCLE_UNIT = `CYCLE_UNIT_NS;
   localparam integer TOP_INT = PATTERN_BITS - 1;
   localparam [3:0] TOP_BIT = TOP_INT[3:0];

   // software state
   reg casc_en;
   reg casc_tail;
   reg [2:0] wave_sel;
   reg [15:0] repeat_cnt;
   reg [31:0] cycle_width;
   reg [15:0] cycle_count;
   reg [15:0] pattern;
   reg [15:0] pulse_width;
   reg trigger_unit_enable;
   reg tail_present;

   // generator state
   reg [3:0] state;
   reg [16:0] done_cnt;
   reg [3:0] bit_idx;
   reg [3:0] next_state;
   reg [16:0] next_done_cnt;
   reg [3:0] next_bit_idx;
   reg next_wave_out;
   reg restart;

   wire setup;
   wire wr_access;
   wire mapped;
   wire idle_high;
   wire [TW-1:0] pulse_ns;
   wire [TW-1:0] cycle_ns;
   wire [TW-1:0] seg_a;
   wire [TW-1:0] seg_b;
   wire hit_a;
   wire hit_b;
   wire [16:0] done_inc;
   wire periodic_last;
   wire pattern_endless;
   wire pattern_by_pass;
   wire pattern_last;
   wire active_level;

   assign setup = psel & ~penable;
   // pready is high in the first access cycle, so no wait states
   assign wr_access = psel & penable & pready & pwrite;
   assign mapped = (paddr == `REG_CTRL_ONE) | (paddr == `REG_CYCLE_WIDTH) | (paddr == `REG_COUNT_PATTERN) |
                   (paddr == `REG_PULSE_WIDTH) | (paddr == `REG_UNIT_CTRL) | (paddr == `REG_UNIT_STATUS);

   // (R13) pulse width scaled by 8 ns
   assign pulse_ns = {{(TW-16){1'b0}}, pulse_width} * PULSE_UNIT;
   // (R14) cycle width scaled by 1 ns
   assign cycle_ns = {{(TW-32){1'b0}}, cycle_width} * CYCLE_UNIT;
   // (R10) clamp levels to the fastest toggle
   assign seg_a = (pulse_ns < MIN_SEG) ? MIN_SEG : pulse_ns;
   assign seg_b = (cycle_ns < MIN_SEG) ? MIN_SEG : cycle_ns;

   // (R3) high idle for the falling-edge style codes
   assign idle_high = (wave_sel == `WAVE_FALL) | (wave_sel == `WAVE_LOW_PULSE) | (wave_sel == `WAVE_LOW_PERIODIC);
   assign active_level = ~idle_high;

   assign done_inc = done_cnt + 17'h0_0001;
   // (R7) zero cycle count never finishes
   assign periodic_last = (cycle_count != 16'h0000) & (done_inc == {1'b0, cycle_count});
   // (R12) chain without a tail loops forever
   assign pattern_endless = casc_en & ~casc_tail & ~tail_present;
   // (R15) only the tail counts whole passes
   assign pattern_by_pass = casc_en & casc_tail;
   // (R11) repeat value plus one passes
   assign pattern_last = pattern_endless ? 1'b0 :
                         pattern_by_pass ? ((bit_idx == 4'h0) & (done_cnt == {1'b0, repeat_cnt})) :
                         ((cycle_count != 16'h0000) & (done_inc == {1'b0, cycle_count}));

   ns_span_timer #(
      .TW(TW)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .restart(restart),
      .target_a(seg_a),
      .target_b(seg_b),
      .hit_a(hit_a),
      .hit_b(hit_b)
   );

   always @* begin
      next_state = state;
      next_done_cnt = done_cnt;
      next_bit_idx = bit_idx;
      next_wave_out = wave_out;
      restart = 1'b0;
      case (state)
         S_IDLE: begin
            next_wave_out = (wave_sel == `WAVE_PATTERN) ? 1'b0 : idle_high;
            next_done_cnt = 17'h0_0000;
            next_bit_idx = TOP_BIT;
            // (R1) start on enable and time reached
            if (trigger_unit_enable & time_reached) begin
               restart = 1'b1;
               case (wave_sel)
                  `WAVE_FALL: begin
                     // (R3) go low and stay
                     next_wave_out = 1'b0;
                     next_state = S_HOLD;
                  end
                  `WAVE_RISE: begin
                     // (R4) go high and stay
                     next_wave_out = 1'b1;
                     next_state = S_HOLD;
                  end
                  `WAVE_LOW_PULSE, `WAVE_HIGH_PULSE, `WAVE_LOW_PERIODIC, `WAVE_HIGH_PERIODIC: begin
                     next_wave_out = active_level;
                     next_state = S_ACT;
                  end
                  `WAVE_PATTERN: begin
                     // (R9) msb first
                     next_wave_out = pattern[TOP_BIT];
                     next_state = S_ACT;
                  end
                  default: begin
                     // (R2) reserved code produces nothing
                     next_state = S_IDLE;
                  end
               endcase
            end
         end
         S_ACT: begin
            if (wave_sel == `WAVE_PATTERN) begin
               // (R9) one bit per cycle width, looping
               if (hit_b) begin
                  restart = 1'b1;
                  if (pattern_last) begin
                     next_wave_out = 1'b0;
                     next_state = S_HOLD;
                  end else begin
                     next_bit_idx = bit_idx - 4'h1;
                     next_wave_out = pattern[bit_idx - 4'h1];
                     if (pattern_by_pass) begin
                        if (bit_idx == 4'h0) begin
                           next_done_cnt = done_inc;
                        end
                     end else begin
                        next_done_cnt = done_inc;
                     end
                  end
               end
            end else if (hit_a) begin
               next_wave_out = idle_high;
               if ((wave_sel == `WAVE_LOW_PULSE) | (wave_sel == `WAVE_HIGH_PULSE)) begin
                  // (R5) (R6) single pulse then idle level
                  next_state = S_HOLD;
               end else begin
                  next_state = S_REST;
               end
            end
         end
         S_REST: begin
            // (R7) (R8) period measured from pulse start
            if (hit_b) begin
               restart = 1'b1;
               next_done_cnt = done_inc;
               if (periodic_last) begin
                  next_state = S_HOLD;
               end else begin
                  next_wave_out = active_level;
                  next_state = S_ACT;
               end
            end
         end
         S_HOLD: begin
            next_state = S_HOLD;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      // clearing the enable aborts and re-arms
      if (!trigger_unit_enable) begin
         next_state = S_IDLE;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         done_cnt <= 17'h0_0000;
         bit_idx <= 4'hf;
         wave_out <= 1'b1;
      end else begin
         state <= next_state;
         done_cnt <= next_done_cnt;
         bit_idx <= next_bit_idx;
         wave_out <= next_wave_out;
      end
   end

   // apb slave: answer and read data prepared in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= 32'h0000_0000;
         if (setup & ~pwrite) begin
            case (paddr)
               `REG_CTRL_ONE: begin
                  prdata <= {casc_en, casc_tail, 7'h00, wave_sel, 4'h0, repeat_cnt};
               end
               `REG_CYCLE_WIDTH: begin
                  prdata <= cycle_width;
               end
               `REG_COUNT_PATTERN: begin
                  prdata <= {cycle_count, pattern};
               end
               `REG_PULSE_WIDTH: begin
                  prdata <= {16'h0000, pulse_width};
               end
               `REG_UNIT_CTRL: begin
                  prdata <= {30'h0000_0000, tail_present, trigger_unit_enable};
               end
               `REG_UNIT_STATUS: begin
                  prdata <= {done_cnt[15:0], 4'h0, bit_idx, 3'h0, wave_out, state};
               end
               default: begin
                  prdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         casc_en <= 1'b0;
         casc_tail <= 1'b0;
         // (R2) select resets to 000
         wave_sel <= `WAVE_FALL;
         // (R11) repeat count resets to zero
         repeat_cnt <= 16'h0000;
         cycle_width <= 32'h0000_0000;
         cycle_count <= 16'h0000;
         pattern <= 16'h0000;
         pulse_width <= 16'h0000;
         trigger_unit_enable <= 1'b0;
         tail_present <= 1'b0;
      end else if (wr_access & ~pslverr) begin
         case (paddr)
            `REG_CTRL_ONE: begin
               casc_en <= pwdata[`CASC_EN_BIT];
               casc_tail <= pwdata[`CASC_TAIL_BIT];
               wave_sel <= pwdata[`WAVE_SEL_HI:`WAVE_SEL_LO];
               repeat_cnt <= pwdata[`REPEAT_HI:`REPEAT_LO];
            end
            `REG_CYCLE_WIDTH: begin
               cycle_width <= pwdata;
            end
            `REG_COUNT_PATTERN: begin
               cycle_count <= pwdata[`CYC_COUNT_HI:`CYC_COUNT_LO];
               pattern <= pwdata[`PATTERN_HI:`PATTERN_LO];
            end
            `REG_PULSE_WIDTH: begin
               pulse_width <= pwdata[15:0];
            end
            `REG_UNIT_CTRL: begin
               trigger_unit_enable <= pwdata[`TRIGGER_UNIT_ENABLE_BIT];
               tail_present <= pwdata[`TAIL_PRESENT_BIT];
            end
            default: begin
               tail_present <= tail_present;
            end
         endcase
      end
   end
endmodule

// ---- testbench/ptp_trig_props.sv ----
// assertion checker on the trigger waveform block ports
`timescale 1ns/1ps
module ptp_trig_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire time_reached,
   input wire wave_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   a_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error outside access");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_reset_idle: assert property ($rose(presetn) |-> wave_out)
      else $error("output not idle high after reset");
   // level held at least 40 ns while a run is live
   a_min_segment: assert property ($changed(wave_out) && time_reached |=> $stable(wave_out) [*3])
      else $error("output level shorter than 40 ns");
endmodule
bind ptp_trigger_waveform_select ptp_trig_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .time_reached(time_reached), .wave_out(wave_out));

// ---- testbench/tb_ptp_trigger_waveform_select.sv ----
// self-checking bench for the trigger waveform block
`timescale 1ns/1ps
module tb_ptp_trigger_waveform_select;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic time_reached = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wave_out;
   logic [31:0] rd;
   logic [31:0] d;
   logic er;
   logic [31:0] masks [5] = '{32'hc070ffff, 32'hffffffff, 32'hffffffff, 32'h0000ffff, 32'h00000003};
   int errors = 0;
   int total_checks = 0;
   int i;
   always #5 pclk = ~pclk;
   ptp_trigger_waveform_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .time_reached(time_reached), .wave_out(wave_out));
   task end_sim;
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         errors++;
         end_sim;
      end
   endtask
   // segment length in cycles, clamped to the 40 ns floor
   function automatic int seg(input int ns);
      return ((ns < 40 ? 40 : ns) + 9) / 10;
   endfunction
   task run(input int code, cw, cnt, pw, casc, tail, tailp, rep, win);
      int pat, k, v, sp, per, tot, bi;
      pat = $urandom & 32'hffff;
      apb(1'b1, 8'h04, cw);
      apb(1'b1, 8'h08, (cnt << 16) | pat);
      apb(1'b1, 8'h0c, pw);
      apb(1'b1, 8'h00, (casc << 31) | (tail << 30) | (code << 20) | rep);
      apb(1'b1, 8'h10, 1 | (tailp << 1));
      repeat (6) @(posedge pclk);
      #1;
      chk("idle level", {31'h0, wave_out}, {31'h0, code == 0 || code == 2 || code == 4});
      @(posedge pclk);
      time_reached <= 1'b1;
      sp = seg(pw * 8);
      per = seg(cw);
      tot = casc ? (tail ? (rep + 1) * 16 : (tailp ? cnt : 0)) : cnt;
      for (k = 0; k < win; k++) begin
         @(posedge pclk);
         #1;
         bi = k / per;
         case (code)
            0: v = 0;
            1: v = 1;
            2: v = k >= sp;
            3: v = k < sp;
            4, 5: v = ((cnt != 0 && bi >= cnt) || k % per >= sp) ? (code == 4) : (code == 5);
            default: v = (tot != 0 && bi >= tot) ? 0 : (pat >> (15 - bi % 16)) & 1;
         endcase
         chk("wave_out", {31'h0, wave_out}, v); // shape per code
      end
      @(posedge pclk);
      time_reached <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b1, 8'h10, 32'h0);
      repeat (6) @(posedge pclk);
   endtask
   initial begin
      void'($urandom(32'h617a));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 6; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", rd, i == 5 ? 32'hf11 : 32'h0);
      end
      for (i = 0; i < 5; i++) begin
         d = $urandom;
         apb(1'b1, 8'(i * 4), d);
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("readback", rd, d & masks[i]);
         chk("readback error", {31'h0, er}, 32'h0);
      end
      apb(1'b1, 8'h40, 32'hffffffff);
      chk("unmapped write error", {31'h0, er}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", rd, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h10, 32'h0);
      repeat (6) @(posedge pclk);
      time_reached <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk("wave_out while disabled", {31'h0, wave_out}, 32'h1);
      @(posedge pclk);
      time_reached <= 1'b0;
      apb(1'b1, 8'h00, 32'h00700000);
      apb(1'b1, 8'h10, 32'h1);
      @(posedge pclk);
      #1;
      d = {31'h0, wave_out};
      @(posedge pclk);
      time_reached <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk("wave_out reserved code", {31'h0, wave_out}, d);
      apb(1'b0, 8'h14, 32'h0);
      chk("state reserved code", rd & 32'hf, 32'h1);
      @(posedge pclk);
      time_reached <= 1'b0;
      apb(1'b1, 8'h10, 32'h0);
      run(0, 40, 0, 1, 0, 0, 0, 0, 6);
      run(1, 40, 0, 1, 0, 0, 0, 0, 6);
      run(2, 40, 0, 10, 0, 0, 0, 0, 14);
      run(3, 40, 0, 3, 0, 0, 0, 0, 10);
      run(4, 100, 2, 5, 0, 0, 0, 0, 26);
      run(5, 90, 0, 4, 0, 0, 0, 0, 27);
      run(6, 40, 20, 1, 0, 0, 0, 0, 90);
      run(6, 45, 9, 1, 1, 1, 0, 1, 170);
      run(6, 40, 5, 1, 1, 0, 0, 3, 160);
      run(6, 40, 5, 1, 1, 0, 1, 3, 30);
      apb(1'b1, 8'h00, 32'h00100000);
      repeat (6) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      chk("wave_out in reset", {31'h0, wave_out}, 32'h1);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk("control after reset", rd, 32'h0);
      end_sim;
   end
endmodule
